//--- dv/shutoff_props.sv
/*
  assertions on the pins of the emergency shutoff block
  assumes it is bound to the top module and sees only its ports
*/
`timescale 1ns/1ps
`default_nettype none
module shutoff_props
  import shutoff_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic fault_in_0_n,
  input wire logic osc_stopped,
  input wire logic [15:0] tmr_out,
  input wire logic [15:0] tmr_oe,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe
);
  logic up; // high from the first edge after reset
  logic wp; // write data phase under way
  logic [5:0] wi; // word index of that write
  logic [10:0][15:0] cfg; // last value written to each register
  logic [15:0] swm; // pins floated by software request
  logic [15:0] enm; // pins carrying a shutdown enable
  // software groups and enabled pins from the snooped registers
  always_comb
  begin
    swm = {16{cfg[7][SW_CH34_BIT]}} & SW_CH34_MASK;
    swm |= {16{cfg[7][SW_CH67_BIT]}} & SW_CH67_MASK;
    swm |= {16{cfg[7][SW_CH0_BIT]}} & SW_CH0_MASK;
    enm = {12'h000, cfg[8][3:0]};
    for (int p = 0; p < NUM_PAIRS; p++)
    begin
      enm[PAIR_A[p]] |= cfg[9][PAIR_EN_BIT[p]];
      enm[PAIR_B[p]] |= cfg[9][PAIR_EN_BIT[p]];
    end
  end
  // snoop writes, landing on the same edge as the register itself
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      up <= 1'h0;
      wp <= 1'h0;
      wi <= 6'h00;
      cfg <= {11{16'h0000}};
    end
    else
    begin
      up <= 1'h1;
      wp <= hsel && htrans[1] && hready && hwrite;
      wi <= haddr[7:2];
      if (wp && wi < 6'h0b)
        cfg[wi[3:0]] <= hwdata[15:0];
    end
  end
  chk_pin_copy: assert property (@(posedge clk) disable iff (!arst_n)
    up |-> pin_out == $past(tmr_out)) else $error("pin level is not the timer level");
  chk_oe_gate: assert property (@(posedge clk) disable iff (!arst_n)
    up |-> (pin_oe & ~$past(tmr_oe)) == 16'h0000) else $error("pin driven while timer idle");
  chk_sw_float: assert property (@(posedge clk) disable iff (!arst_n)
    up && swm != 16'h0000 |=> (pin_oe & $past(swm)) == 16'h0000)
    else $error("software group still driven");
  chk_enable_only: assert property (@(posedge clk) disable iff (!arst_n)
    up && swm == 16'h0000 && $past(swm) == 16'h0000
    |-> (~enm & ~$past(enm) & ~pin_oe & $past(tmr_oe)) == 16'h0000)
    else $error("pin without enable floated");
  chk_edge_float: assert property (@(posedge clk) disable iff (!arst_n)
    up && cfg[0][1:0] == 2'h0 && cfg[0][9] && $fell(fault_in_0_n)
    |-> ##[1:4] (pin_oe & enm) == 16'h0000) else $error("fault edge did not float pins");
  chk_osc_float: assert property (@(posedge clk) disable iff (!arst_n)
    up && osc_stopped && cfg[10][9] |-> ##[1:4] (pin_oe & enm) == 16'h0000)
    else $error("oscillator stop did not float pins");
  chk_pair_float: assert property (@(posedge clk) disable iff (!arst_n)
    up && cfg[5][9] && cfg[9][10] && tmr_oe[5:4] == 2'h3 && tmr_out[5:4] == {2{cfg[6][0]}}
    |-> ##[1:4] pin_oe[5:4] == 2'h0) else $error("pair overlap did not float pair");
  chk_float_hold: assert property (@(posedge clk) disable iff (!arst_n)
    up && !wp && !$past(wp) && !pin_oe[0] && $past(tmr_oe[0])
    |=> !pin_oe[0] || !$past(tmr_oe[0])) else $error("float released without a write");
endmodule : shutoff_props
`default_nettype wire

//--- dv/test_timer_output_emergency_shutoff.sv
/*
  self-checking bench for the emergency shutoff block
  assumes the timer and fault model and the bound checker
*/
`timescale 1ns/1ps
`default_nettype none
bind timer_output_emergency_shutoff shutoff_props i_props (.clk(clk), .arst_n(arst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .fault_in_0_n(fault_in_0_n), .osc_stopped(osc_stopped),
  .tmr_out(tmr_out), .tmr_oe(tmr_oe), .pin_out(pin_out), .pin_oe(pin_oe));
module test_timer_output_emergency_shutoff
  import shutoff_pkg::*;
;
  logic clk = 1'h0, arst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, osc_stopped = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rnd = 32'h0, hrdata, q, cv;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, irq_req, oe_all = 1'h0;
  logic [15:0] tmr_out, tmr_oe, pin_out, pin_oe, oe_q;
  logic [4:0] low = 5'h00, fault_n;
  logic [5:0] ovl = 6'h00, act_high = 6'h00;
  logic [15:0] pe_t [5] = '{16'h0100, 16'h0200, 16'h0400, 16'h0004, 16'h0003};
  logic [15:0] pm_t [5] = '{16'h0285, 16'h014a, 16'h0035, 16'h0c0a, 16'hf005};
  logic [15:0] sw_t [3] = '{16'h03f0, 16'hfc00, 16'h000f};
  integer seed = 32'h022f6899;
  int errors = 0, n_checks = 0, i, k, dv;
  always #50 clk = ~clk;
  // fresh timer levels each cycle, and the enables the pins should follow
  always @(posedge clk)
  begin
    rnd <= $random(seed);
    oe_q <= tmr_oe;
  end
  timer_output_emergency_shutoff i_dut (.clk(clk), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .fault_in_0_n(fault_n[0]), .fault_in_4_n(fault_n[1]), .fault_in_8_n(fault_n[2]),
    .fault_in_10_n(fault_n[3]), .fault_in_11_n(fault_n[4]), .osc_stopped(osc_stopped),
    .tmr_out(tmr_out), .tmr_oe(tmr_oe), .pin_out(pin_out), .pin_oe(pin_oe),
    .irq_req(irq_req));
  timer_fault_model i_model (.rnd(rnd), .low(low), .ovl(ovl), .act_high(act_high),
    .oe_all(oe_all), .fault_n(fault_n), .tmr_out(tmr_out), .tmr_oe(tmr_oe));
  // counts, verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hreadyout !== 1'h1 && n < 16);
    if (hreadyout !== 1'h1)
    begin
      errors++;
      report_and_stop();
    end
  endtask : wait_rdy
  // one single word transfer, read data kept in q
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask : wr
  // word compare
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %0s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  task automatic check_reg(input logic [7:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    cmp($sformatf("reg %h", a), e, q);
    cmp("hresp", 32'h0, {31'h0, hresp});
  endtask : check_reg
  // pin enable compare, m is the set of pins expected to float
  task automatic check_oe(input logic [15:0] m);
    @(posedge clk);
    @(negedge clk);
    n_checks++;
    if (pin_oe !== (oe_q & ~m))
    begin
      errors++;
      $display("wrong value pin_oe expected %h seen %h", oe_q & ~m, pin_oe);
    end
    @(posedge clk);
  endtask : check_oe
  task automatic done(input string s);
    $display("test %0s finished", s);
  endtask : done
  initial
  begin
    repeat (4) @(posedge clk);
    cmp("pin_oe in reset", 32'h0, {16'h0, pin_oe});
    arst_n <= 1'h1;
    @(posedge clk);
    for (i = 0; i < 12; i++)
      check_reg(8'(i * 4), 32'h0);
    wr(8'h2c, 32'hffffffff);
    check_reg(8'h2c, 32'h0);
    done("reset");
    repeat (20) check_oe(16'h0000);
    oe_all <= 1'h1;
    for (i = 0; i < 3; i++)
    begin
      wr(8'h1c, 32'h1 << i);
      check_reg(8'h1c, 32'h1 << i);
      check_oe(sw_t[i]);
      wr(8'h1c, 32'h0);
      check_oe(16'h0000);
    end
    done("software");
    for (k = 0; k < 5; k++)
    begin
      cv = k[0] ? 32'h0200 : 32'h0300;
      wr(8'h20, k[0] ? 32'ha : 32'h5);
      wr(8'h24, {16'h0, pe_t[k]});
      wr(8'(k * 4), cv);
      low[k] <= 1'h1;
      @(posedge clk);
      low[k] <= 1'h0;
      repeat (3) @(posedge clk);
      wr(8'(k * 4), cv);
      check_reg(8'(k * 4), cv | 32'h1000);
      cmp("irq_req", {31'h0, ~k[0]}, {31'h0, irq_req});
      check_oe(pm_t[k]);
      wr(8'(k * 4), cv);
      check_reg(8'(k * 4), cv);
      check_oe(16'h0000);
      wr(8'(k * 4), 32'h0);
    end
    done("edge");
    wr(8'h20, 32'hf);
    wr(8'h24, 32'h0);
    for (i = 1; i < 4; i++)
    begin
      dv = (i == 1) ? 8 : (i == 2) ? 16 : 128;
      cv = 32'h0200 | 32'(i);
      wr(8'h00, cv);
      low[0] <= 1'h1;
      repeat (14 * dv) @(posedge clk);
      low[0] <= 1'h0;
      check_reg(8'h00, cv);
      low[0] <= 1'h1;
      repeat (18 * dv) @(posedge clk);
      check_reg(8'h00, cv | 32'h1000);
      wr(8'h00, cv);
      low[0] <= 1'h0;
      check_reg(8'h00, cv | 32'h1000);
      repeat (dv) @(posedge clk);
      wr(8'h00, cv);
      check_reg(8'h00, cv);
    end
    done("level");
    wr(8'h20, 32'h0);
    wr(8'h24, 32'h0400);
    wr(8'h14, 32'h0300);
    for (i = 0; i < 2; i++)
    begin
      wr(8'h18, 32'(i));
      check_reg(8'h18, 32'(i));
      act_high[0] <= i[0];
      ovl[0] <= 1'h1;
      @(posedge clk);
      ovl[0] <= 1'h0;
      repeat (3) @(posedge clk);
      check_reg(8'h14, 32'h1300);
      cmp("irq_req", 32'h1, {31'h0, irq_req});
      check_oe(16'h0030);
      wr(8'h14, 32'h0300);
      check_reg(8'h14, 32'h0300);
    end
    done("pair");
    wr(8'h20, 32'hf);
    wr(8'h28, 32'h0200);
    osc_stopped <= 1'h1;
    repeat (4) @(posedge clk);
    check_oe(16'h003f);
    osc_stopped <= 1'h0;
    check_reg(8'h28, 32'h1200);
    wr(8'h28, 32'h0200);
    check_reg(8'h28, 32'h0200);
    check_oe(16'h0000);
    done("oscillator");
    wr(8'h1c, 32'h7);
    arst_n <= 1'h0;
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    check_reg(8'h1c, 32'h0);
    check_oe(16'h0000);
    done("second reset");
    report_and_stop();
  end
endmodule : test_timer_output_emergency_shutoff
`default_nettype wire

//--- dv/timer_fault_model.sv
/*
  timer outputs and fault pins seen from the far side
  assumes the bench feeds a fresh random word after every edge
*/
`timescale 1ns/1ps
`default_nettype none
module timer_fault_model
  import shutoff_pkg::*;
(
  input wire logic [31:0] rnd, // random levels and enables
  input wire logic [4:0] low, // fault pins to pull low
  input wire logic [5:0] ovl, // pairs to drive both active
  input wire logic [5:0] act_high, // active level per pair
  input wire logic oe_all, // drive every timer output
  output logic [4:0] fault_n,
  output logic [15:0] tmr_out,
  output logic [15:0] tmr_oe
);
  // complementary members never active together unless commanded
  always_comb
  begin
    tmr_out = rnd[15:0];
    tmr_oe = rnd[31:16] | {16{oe_all}};
    for (int p = 0; p < NUM_PAIRS; p++)
    begin
      tmr_out[PAIR_B[p]] = ~tmr_out[PAIR_A[p]];
      if (ovl[p])
      begin
        tmr_out[PAIR_A[p]] = act_high[p];
        tmr_out[PAIR_B[p]] = act_high[p];
      end
    end
    fault_n = ~low;
  end
endmodule : timer_fault_model
`default_nettype wire

//--- rtl/fault_if.sv
/*
  carrier between the shutoff controller and one fault input qualifier
  assumes the controller drives mode, sample ticks and the raw pin
*/
`timescale 1ns/1ps
`default_nettype none
interface fault_if;
  import shutoff_pkg::*;
  logic fault_n; // raw fault pin, low means fault
  det_mode_t mode; // edge or sampled low level
  logic tick8; // one pulse every 8 clocks
  logic tick16; // one pulse every 16 clocks
  logic tick128; // one pulse every 128 clocks
  logic hit; // qualified detection
  modport ctrl (output fault_n, output mode, output tick8, output tick16,
                output tick128, input hit);
  modport filt (input fault_n, input mode, input tick8, input tick16,
                input tick128, output hit);
endinterface : fault_if
`default_nettype wire

//--- rtl/fault_qualifier.sv
/*
  qualifies one active-low fault input by falling edge or by 16 low samples
  assumes the fault pin is synchronous to clk
*/
`timescale 1ns/1ps
`default_nettype none
module fault_qualifier
  import shutoff_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  fault_if.filt fi
);
  typedef struct packed {
    logic prev; // pin value one clock ago
    logic [4:0] cnt; // consecutive low samples
    logic hit; // registered detection
  } fq_state_t;
  fq_state_t s_reg;
  fq_state_t s_next;
  logic tick; // sample strobe of the chosen rate

  // next state: edge detector or saturating low-sample counter
  always_comb
  begin
    s_next = s_reg;
    s_next.prev = fi.fault_n;
    case (fi.mode)
      DET_DIV8: tick = fi.tick8;
      DET_DIV16: tick = fi.tick16;
      DET_DIV128: tick = fi.tick128;
      default: tick = 1'b0;
    endcase
    if (fi.mode == DET_EDGE)
    begin
      // falling edge gives a one-clock hit
      s_next.cnt = 5'h00;
      s_next.hit = s_reg.prev & ~fi.fault_n;
    end
    else
    begin
      if (tick && !fi.fault_n && s_reg.cnt != LEVEL_SAMPLES)
        s_next.cnt = s_reg.cnt + 5'h01;
      else if (tick && fi.fault_n)
        s_next.cnt = 5'h00;
      s_next.hit = (s_next.cnt == LEVEL_SAMPLES);
    end
  end

  // state register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      s_reg <= '{prev: 1'b1, cnt: 5'h00, hit: 1'b0};
    else
      s_reg <= s_next;
  end

  assign fi.hit = s_reg.hit;
endmodule : fault_qualifier
`default_nettype wire

//--- rtl/pair_compare.sv
/*
  flags complementary pairs whose two outputs sit at the active level together
  assumes timer output levels are synchronous to clk
*/
`timescale 1ns/1ps
`default_nettype none
module pair_compare
  import shutoff_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [15:0] level,
  input wire logic [5:0] act_high,
  output logic [5:0] hit
);
  typedef struct packed {
    logic [5:0] hit; // pair seen both active
  } pc_state_t;
  pc_state_t s_reg;
  pc_state_t s_next;

  // both members at the active level for one clock is a hit
  always_comb
  begin
    s_next = s_reg;
    for (int p = 0; p < NUM_PAIRS; p++)
      s_next.hit[p] = (level[PAIR_A[p]] == act_high[p])
                    && (level[PAIR_B[p]] == act_high[p]);
  end

  // state register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign hit = s_reg.hit;
endmodule : pair_compare
`default_nettype wire

//--- rtl/shutoff_pkg.sv
/*
  constants, field layouts and reset values shared by the emergency shutoff block
  assumes a 10 mhz peripheral clock and a 32-bit ahb-lite register bus
*/
package shutoff_pkg;
  // pin numbering of the sixteen controlled timer outputs
  // 0..3 ch0 a..d, 4 ch3 b, 5 ch3 d, 6..9 ch4 a..d, 10 ch6 b, 11 ch6 d, 12..15 ch7 a..d
  localparam int NUM_PINS = 16;
  localparam int NUM_FAULTS = 5; // fault inputs 0, 4, 8, 10, 11
  localparam int NUM_PAIRS = 6; // 3b/3d 4a/4c 4b/4d 6b/6d 7a/7c 7b/7d
  // pin index of the two members of each complementary pair
  localparam logic [5:0][3:0] PAIR_A = {4'hd, 4'hc, 4'ha, 4'h7, 4'h6, 4'h4};
  localparam logic [5:0][3:0] PAIR_B = {4'hf, 4'he, 4'hb, 4'h9, 4'h8, 4'h5};
  // pins hit by each software request bit
  localparam logic [15:0] SW_CH0_MASK = 16'h000f;
  localparam logic [15:0] SW_CH34_MASK = 16'h03f0;
  localparam logic [15:0] SW_CH67_MASK = 16'hfc00;
  // byte offsets on the register bus
  localparam logic [4:0][7:0] FICS_OFS = {8'h10, 8'h0c, 8'h08, 8'h04, 8'h00};
  localparam logic [7:0] OCS_OFS = 8'h14; // output compare status 2
  localparam logic [7:0] ALV_OFS = 8'h18; // active level config
  localparam logic [7:0] SWR_OFS = 8'h1c; // software shutdown request
  localparam logic [7:0] CH0E_OFS = 8'h20; // channel 0 pin enable
  localparam logic [7:0] PAIRE_OFS = 8'h24; // complementary pair enable
  localparam logic [7:0] OSC_OFS = 8'h28; // oscillator stop control/status
  // fields shared by fault, compare and oscillator status registers
  localparam int MODE_LSB = 0;
  localparam int IRQ_EN_BIT = 8;
  localparam int HIZ_EN_BIT = 9;
  localparam int FLAG_BIT = 12;
  // software request bits
  localparam int SW_CH34_BIT = 0;
  localparam int SW_CH67_BIT = 1;
  localparam int SW_CH0_BIT = 2;
  // bit of each pair in the pair enable register, pair order as PAIR_A
  localparam logic [5:0][3:0] PAIR_EN_BIT = {4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'ha};
  // detection modes
  typedef enum logic [1:0] {
    DET_EDGE = 2'b00,
    DET_DIV8 = 2'b01,
    DET_DIV16 = 2'b10,
    DET_DIV128 = 2'b11
  } det_mode_t;
  localparam logic [4:0] LEVEL_SAMPLES = 5'h10; // consecutive low samples needed
  localparam logic [6:0] PRESC_RESET = 7'h00;
  localparam logic [15:0] REG_RESET = 16'h0000;
endpackage : shutoff_pkg

//--- rtl/timer_output_emergency_shutoff.sv
/*
  emergency output disable for the motor timer pins, with ahb-lite registers
  assumes timer outputs, fault pins and oscillator status are synchronous to clk
*/
`timescale 1ns/1ps
`default_nettype none
module timer_output_emergency_shutoff
  import shutoff_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // fault inputs 0, 4, 8, 10, 11 in that order
  input wire logic fault_in_0_n,
  input wire logic fault_in_4_n,
  input wire logic fault_in_8_n,
  input wire logic fault_in_10_n,
  input wire logic fault_in_11_n,
  // main oscillator stop report
  input wire logic osc_stopped,
  // motor_timer side of the controlled pins
  input wire logic [15:0] tmr_out,
  input wire logic [15:0] tmr_oe,
  // pin side
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe,
  // interrupt request, level
  output logic irq_req
);
  typedef struct packed {
    logic [4:0][1:0] mode; // fault detection modes
    logic [4:0] f_irq_en; // fault interrupt enables
    logic [4:0] f_hiz_en; // fault float enables
    logic [4:0] f_flag; // fault detection flags
    logic [4:0] f_seen; // flag read as one since set
    logic c_irq_en; // compare interrupt enable
    logic c_hiz_en; // compare float enable
    logic c_flag; // compare detection flag
    logic c_seen; // compare flag read as one
    logic [5:0] act_high; // active level per pair, 1 = high
    logic [2:0] sw_req; // software float requests
    logic [3:0] ch0_en; // channel 0 pin enables
    logic [5:0] pair_en; // pair enables in pair order
    logic o_hiz_en; // oscillator stop float enable
    logic o_flag; // oscillator stop flag
    logic o_seen; // oscillator flag read as one
    logic [6:0] presc; // sample prescaler
    logic dph_wr; // write data phase pending
    logic [7:0] dph_addr; // address of that write
    logic [31:0] rdata; // read data for the data phase
    logic [15:0] pin_out; // registered pin level
    logic [15:0] pin_oe; // registered pin enable
  } sh_state_t;

  // all state sits in one struct
  // one always_ff registers the copy
  // so every register runs each edge
  // and none of them needs an enable
  sh_state_t s_reg;
  sh_state_t s_next;
  // one carrier per qualifier
  // ticks are shared, so all inputs
  // sample on one prescaler phase
  fault_if fif [NUM_FAULTS] ();
  logic [4:0] fault_n; // fault pins as a vector
  logic [4:0] f_hit; // qualified fault hits
  logic [5:0] pair_hit; // pairs seen both active
  logic [5:0] pair_en_now; // enabled pairs currently in conflict
  logic [15:0] hiz; // pins to float
  logic all_src; // shutdown of all enabled pins
  logic cmp_src; // shutdown of enabled complementary pins
  logic take; // accepted address phase
  logic [7:0] a_ofs; // low address byte of the address phase

  assign fault_n = {fault_in_11_n, fault_in_10_n, fault_in_8_n, fault_in_4_n, fault_in_0_n};

  // prescaler is never cleared by a
  // mode write: the first sample may
  // come up to one period later
  // one qualifier per fault input
  for (genvar g = 0; g < NUM_FAULTS; g++)
  begin : g_fault
    assign fif[g].fault_n = fault_n[g];
    assign fif[g].mode = det_mode_t'(s_reg.mode[g]);
    assign fif[g].tick8 = (s_reg.presc[2:0] == 3'h7);
    assign fif[g].tick16 = (s_reg.presc[3:0] == 4'hf);
    assign fif[g].tick128 = (s_reg.presc == 7'h7f);
    assign f_hit[g] = fif[g].hit;
    fault_qualifier u_fq (
      .clk(clk),
      .arst_n(arst_n),
      .fi(fif[g])
    );
  end

  // levels only: undriven pins
  // still take part in the compare
  // complementary pair level comparison
  pair_compare u_pc (
    .clk(clk),
    .arst_n(arst_n),
    .level(tmr_out),
    .act_high(s_reg.act_high),
    .hit(pair_hit)
  );

  // a flag drops only after it was
  // read as set and zero is written
  // with its cause gone; a detection
  // in the clear cycle keeps it set
  // read-one then write-zero clear, with a new detection winning
  function automatic logic next_flag(input logic flag, input logic seen,
                                     input logic wr, input logic wbit,
                                     input logic cond);
    logic f;
    f = flag;
    if (wr && !wbit && seen && !cond)
      f = 1'b0;
    if (cond)
      f = 1'b1;
    return f;
  endfunction : next_flag

  // one field layout for fault,
  // compare and oscillator status
  // common layout of a detection control/status register
  function automatic logic [31:0] pack_stat(input logic [1:0] mode, input logic irq_en,
                                            input logic hiz_en, input logic flag);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[MODE_LSB +: 2] = mode;
    v[IRQ_EN_BIT] = irq_en;
    v[HIZ_EN_BIT] = hiz_en;
    v[FLAG_BIT] = flag;
    return v;
  endfunction : pack_stat

  // reads use the next state, so a
  // read after a write sees it
  // register read mux, unmapped addresses read zero
  function automatic logic [31:0] read_reg(input sh_state_t st, input logic [7:0] ofs);
    logic [31:0] v;
    v = 32'h0000_0000;
    for (int i = 0; i < NUM_FAULTS; i++)
      if (ofs == FICS_OFS[i])
        v = pack_stat(st.mode[i], st.f_irq_en[i], st.f_hiz_en[i], st.f_flag[i]);
    case (ofs)
      OCS_OFS: v = pack_stat(2'b00, st.c_irq_en, st.c_hiz_en, st.c_flag);
      ALV_OFS: v[5:0] = st.act_high;
      SWR_OFS: v[2:0] = st.sw_req;
      CH0E_OFS: v[3:0] = st.ch0_en;
      PAIRE_OFS:
      begin
        for (int p = 0; p < NUM_PAIRS; p++)
          v[PAIR_EN_BIT[p]] = st.pair_en[p];
      end
      OSC_OFS: v = pack_stat(2'b00, 1'b0, st.o_hiz_en, st.o_flag);
      default: v = v;
    endcase
    return v;
  endfunction : read_reg

  // faults and oscillator stop only
  // float pins whose enable is set;
  // a pair overlap floats enabled
  // pairs only; software requests
  // float whole channel groups
  // the map reaches the pins only
  // through a register: no glitches
  // float sources and per-pin float map
  always_comb
  begin
    all_src = |(s_reg.f_flag & s_reg.f_hiz_en)
            | (s_reg.o_flag & s_reg.o_hiz_en);
    cmp_src = s_reg.c_flag & s_reg.c_hiz_en;
    hiz = 16'h0000;
    // channel 0 pins follow their own enables
    for (int i = 0; i < 4; i++)
      hiz[i] = all_src & s_reg.ch0_en[i];
    // complementary pins follow their pair enable
    for (int p = 0; p < NUM_PAIRS; p++)
    begin
      hiz[PAIR_A[p]] = (all_src | cmp_src) & s_reg.pair_en[p];
      hiz[PAIR_B[p]] = (all_src | cmp_src) & s_reg.pair_en[p];
    end
    // software requests act on whole channel groups
    if (s_reg.sw_req[SW_CH0_BIT])
      hiz = hiz | SW_CH0_MASK;
    if (s_reg.sw_req[SW_CH34_BIT])
      hiz = hiz | SW_CH34_MASK;
    if (s_reg.sw_req[SW_CH67_BIT])
      hiz = hiz | SW_CH67_MASK;
  end

  // enabled pairs in overlap
  assign pair_en_now = pair_hit & s_reg.pair_en;
  assign take = hsel && htrans[1] && hready;
  assign a_ofs = haddr[7:0];

  // address phase taken with hready
  // high; a write lands at the end of
  // its data phase; a read answers
  // from the edge taking its address
  // so no wait state is ever needed
  // next state: write data phase, detections, read data, pins
  always_comb
  begin
    s_next = s_reg;
    s_next.presc = s_reg.presc + 7'h01;
    // the written flag bit only takes
    // part in the clear protocol
    // fault input registers
    for (int i = 0; i < NUM_FAULTS; i++)
    begin
      if (s_reg.dph_wr && s_reg.dph_addr == FICS_OFS[i])
      begin
        s_next.mode[i] = hwdata[MODE_LSB +: 2];
        s_next.f_irq_en[i] = hwdata[IRQ_EN_BIT];
        s_next.f_hiz_en[i] = hwdata[HIZ_EN_BIT];
      end
      s_next.f_flag[i] = next_flag(s_reg.f_flag[i], s_reg.f_seen[i],
                                   s_reg.dph_wr && s_reg.dph_addr == FICS_OFS[i],
                                   hwdata[FLAG_BIT], f_hit[i]);
      if (!s_next.f_flag[i])
        s_next.f_seen[i] = 1'b0;
    end
    // any enabled pair in overlap sets it
    // output compare status
    if (s_reg.dph_wr && s_reg.dph_addr == OCS_OFS)
    begin
      s_next.c_irq_en = hwdata[IRQ_EN_BIT];
      s_next.c_hiz_en = hwdata[HIZ_EN_BIT];
    end
    s_next.c_flag = next_flag(s_reg.c_flag, s_reg.c_seen,
                              s_reg.dph_wr && s_reg.dph_addr == OCS_OFS,
                              hwdata[FLAG_BIT], |pair_en_now);
    if (!s_next.c_flag)
      s_next.c_seen = 1'b0;
    // sets whatever its enable says
    // oscillator stop status
    if (s_reg.dph_wr && s_reg.dph_addr == OSC_OFS)
      s_next.o_hiz_en = hwdata[HIZ_EN_BIT];
    s_next.o_flag = next_flag(s_reg.o_flag, s_reg.o_seen,
                              s_reg.dph_wr && s_reg.dph_addr == OSC_OFS,
                              hwdata[FLAG_BIT], osc_stopped);
    if (!s_next.o_flag)
      s_next.o_seen = 1'b0;
    // requests stay until zero is written
    // plain control registers
    if (s_reg.dph_wr)
    begin
      case (s_reg.dph_addr)
        ALV_OFS: s_next.act_high = hwdata[5:0];
        SWR_OFS: s_next.sw_req = hwdata[2:0];
        CH0E_OFS: s_next.ch0_en = hwdata[3:0];
        PAIRE_OFS:
        begin
          for (int p = 0; p < NUM_PAIRS; p++)
            s_next.pair_en[p] = hwdata[PAIR_EN_BIT[p]];
        end
        default: s_next.act_high = s_next.act_high;
      endcase
    end
    // reading a set flag arms its clear
    // address phase: latch writes, prepare reads from the updated state
    s_next.dph_wr = take && hwrite;
    s_next.dph_addr = a_ofs;
    if (take && !hwrite)
    begin
      s_next.rdata = read_reg(s_next, a_ofs);
      // a flag read as one arms its clear
      for (int i = 0; i < NUM_FAULTS; i++)
        if (a_ofs == FICS_OFS[i] && s_next.f_flag[i])
          s_next.f_seen[i] = 1'b1;
      if (a_ofs == OCS_OFS && s_next.c_flag)
        s_next.c_seen = 1'b1;
      if (a_ofs == OSC_OFS && s_next.o_flag)
        s_next.o_seen = 1'b1;
    end
    // pins lag the timer by a clock;
    // a float decided now shows at
    // the next edge
    // pins: timer drive passes through unless floated
    s_next.pin_out = tmr_out;
    s_next.pin_oe = tmr_oe & ~hiz;
  end

  // reset clears the pin enables,
  // so pins float until the first
  // edge after release
  // state register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_reg <= '0;
      s_reg.presc <= PRESC_RESET;
      s_reg.pin_out <= REG_RESET;
      s_reg.pin_oe <= REG_RESET;
    end
    else
      s_reg <= s_next;
  end

  // unmapped writes are dropped,
  // unmapped reads return zero,
  // no transfer is ever refused
  // zero-wait slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_reg.rdata;
  assign pin_out = s_reg.pin_out;
  assign pin_oe = s_reg.pin_oe;
  // a level that stays up while an
  // enabled flag is set; oscillator
  // stop never raises it
  // interrupt from enabled fault and compare flags
  assign irq_req = |(s_reg.f_flag & s_reg.f_irq_en) | (s_reg.c_flag & s_reg.c_irq_en);
endmodule : timer_output_emergency_shutoff
`default_nettype wire
